/* File: pkg/result_port_pkg.sv */
// Shared constants for the converter result port and its bus-side reader.
// Assumes a single 20 MHz clock shared by both ends.
`default_nettype none
package result_port_pkg;
	localparam int unsigned MAG_W       = 12;
	localparam int unsigned PORT_W      = 14;
	localparam int unsigned BYTE_W      = 8;
	localparam int unsigned CNT_W       = 14;
	localparam logic [11:0] FULL_SCALE  = 12'hFFF;
	localparam int unsigned LOW_MAG_LSB = 0;
	localparam int unsigned HIGH_MAG_LSB = 8;
	localparam int unsigned SIGN_POS    = 12;
	localparam int unsigned OVER_POS    = 13;
	localparam int unsigned CLK_MHZ     = 20;
	localparam int unsigned RUN_NS      = 2000;
	localparam int unsigned RUN_CYC     = (RUN_NS * CLK_MHZ) / 1000;
	localparam logic [13:0] CNT_RESET   = 14'h0000;
	localparam logic [13:0] CNT_ALL_ONE = 14'h3FFF;
	typedef enum logic [1:0] {
		TEST_GROUND,
		TEST_MID,
		TEST_SUPPLY
	} test_level_t;
endpackage
`default_nettype wire

/* File: pkg/result_port_if.sv */
// Pin-level join between the converter's result port and a bus reader.
// Assumes the bus reader resolves data lines from the output enables.
`timescale 1ns/1ps
`default_nettype none
interface result_port_if;
	logic        chip_enable_n;
	logic        upper_byte_select_n;
	logic        lower_byte_select_n;
	logic        send;
	logic        run_hold;
	logic        status;
	logic [13:0] data;
	logic [13:0] data_oe;
	modport device (
		input  chip_enable_n,
		input  upper_byte_select_n,
		input  lower_byte_select_n,
		input  send,
		input  run_hold,
		output status,
		output data,
		output data_oe
	);
	modport host (
		output chip_enable_n,
		output upper_byte_select_n,
		output lower_byte_select_n,
		output send,
		output run_hold,
		input  status,
		input  data,
		input  data_oe
	);
endinterface
`default_nettype wire

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the destination clock is mclk_in.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         mclk_in,
	input  wire logic         resetn_in,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] reset_val_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// The reset value is a strap-like constant from the caller, loaded synchronously.
	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			meta_q <= reset_val_in;
			sync_q <= reset_val_in;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // pin_sync
`default_nettype wire

/* File: logic/result_port_device.sv */
// Result counter, output latches and three-state byte port of the converter.
// Assumes the bus side keeps send high and drives enables from its own logic.
`timescale 1ns/1ps
`default_nettype none
module result_port_device (
	input  wire logic                        mclk_in,
	input  wire logic                        resetn_in,
	input  wire result_port_pkg::test_level_t test_level_in,
	input  wire logic                        conv_done_in,
	input  wire logic [11:0]                 magnitude_in,
	input  wire logic                        sign_bit_in,
	input  wire logic                        overrange_in,
	input  wire logic                        count_clk_in,
	output logic                             converting_out,
	output logic [13:0]                      counter_out,
	result_port_if.device                    port
);
	logic [4:0]                   pins_sync;
	logic [1:0]                   level_sync;
	result_port_pkg::test_level_t test_level_s;
	logic                         ce_n_s;
	logic                         up_n_s;
	logic                         lo_n_s;
	logic                         run_s;
	logic                         send_s;
	logic                         test_ground;
	logic                         test_mid;
	logic                         counting;
	logic                         conv_start;
	logic                         conv_end;
	logic [13:0]                  result_word;
	logic [13:0]                  count_q;
	logic [13:0]                  count_d;
	logic [13:0]                  latch_q;
	logic [13:0]                  latch_d;
	logic                         test_low_q;
	logic                         test_low_d;
	logic                         busy_q;
	logic                         busy_d;
	logic                         status_q;
	logic                         status_d;
	logic [13:0]                  view;
	logic [13:0]                  oe;

	// Run resets low, so leaving reset never looks like a start request.
	pin_sync #(
		.W (5)
	) u_sync (
		.mclk_in      (mclk_in),
		.resetn_in    (resetn_in),
		.async_in     ({port.chip_enable_n, port.upper_byte_select_n, port.lower_byte_select_n,
		                port.run_hold, port.send}),
		.reset_val_in (5'h1D),
		.sync_out     (pins_sync)
	);
	assign {ce_n_s, up_n_s, lo_n_s, run_s, send_s} = pins_sync;

	// The test pin is a board level as well, so it is synchronised like the bus pins.
	pin_sync #(
		.W (2)
	) u_level_sync (
		.mclk_in      (mclk_in),
		.resetn_in    (resetn_in),
		.async_in     (test_level_in),
		.reset_val_in (result_port_pkg::TEST_SUPPLY),
		.sync_out     (level_sync)
	);
	assign test_level_s = result_port_pkg::test_level_t'(level_sync);

	assign test_ground = (test_level_s == result_port_pkg::TEST_GROUND);
	assign test_mid    = (test_level_s == result_port_pkg::TEST_MID);
	// Ground and the first clock after it own the counter, so conversions wait meanwhile.
	assign counting    = !test_ground && !test_low_q;
	assign conv_start  = counting && !busy_q && run_s;
	assign conv_end    = counting && busy_q && conv_done_in;
	assign result_word = {overrange_in, sign_bit_in, magnitude_in};

	always_comb
	begin
		test_low_d = test_ground;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			test_low_q <= 1'b0;
		end
		else
		begin
			test_low_q <= test_low_d;
		end
	end

	// A start is taken only while idle, so a run level held too long restarts at once.
	always_comb
	begin
		busy_d   = busy_q;
		status_d = status_q;
		if (conv_start)
		begin
			busy_d   = 1'b1;
			status_d = 1'b1;
		end
		else if (conv_end)
		begin
			busy_d   = 1'b0;
			status_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			busy_q   <= 1'b0;
			status_q <= 1'b0;
		end
		else
		begin
			busy_q   <= busy_d;
			status_q <= status_d;
		end
	end

	always_comb
	begin
		count_d = count_q;
		if (test_ground)
		begin
			count_d = result_port_pkg::CNT_ALL_ONE;
		end
		else if (test_low_q)
		begin
			count_d = result_port_pkg::CNT_RESET;
		end
		else if (conv_end)
		begin
			count_d = result_word;
		end
		else if (count_clk_in)
		begin
			if (count_q[11:0] == result_port_pkg::FULL_SCALE)
			begin
				count_d[11:0] = 12'h000;
				count_d[result_port_pkg::OVER_POS] = 1'b1;
			end
			else
			begin
				count_d[11:0] = count_q[11:0] + 12'h001;
			end
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			count_q <= result_port_pkg::CNT_RESET;
		end
		else
		begin
			count_q <= count_d;
		end
	end

	always_comb
	begin
		latch_d = latch_q;
		if (conv_end)
		begin
			latch_d = result_word;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			latch_q <= result_port_pkg::CNT_RESET;
		end
		else
		begin
			latch_q <= latch_d;
		end
	end

	// Mid-level test lets the live counter straight through the latches.
	assign view = test_mid ? count_q : latch_q;

	// Send is sampled but unused: direct mode assumes it is tied high.
	always_comb
	begin
		oe = 14'h0000;
		if (!ce_n_s)
		begin
			if (!lo_n_s)
			begin
				oe[7:0] = 8'hFF;
			end
			if (!up_n_s)
			begin
				oe[13:8] = 6'h3F;
			end
		end
	end

	assign port.data      = view;
	assign port.data_oe   = oe;
	assign port.status    = status_q;
	assign converting_out = busy_q;
	assign counter_out    = count_q;

	logic unused_send;
	assign unused_send = send_s;
endmodule // result_port_device
`default_nettype wire

/* File: logic/result_port_host.sv */
// Bus-side reader: waits for status to fall, then reads high and low bytes.
// Assumes the converter drives data within two cycles of the enables.
`timescale 1ns/1ps
`default_nettype none
module result_port_host (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic        start_in,
	input  wire logic        both_bytes_in,
	output logic             busy_out,
	output logic             result_valid_out,
	output logic [13:0]      result_out,
	result_port_if.host      port
);
	typedef enum {IDLE, WAIT_STATUS, READ_HIGH, READ_LOW, READ_BOTH} host_state_t;
	host_state_t state_q;
	host_state_t state_d;
	logic [1:0]  status_sync_q;
	logic        status_prev_q;
	logic [13:0] data_sync1_q;
	logic [13:0] data_sync2_q;
	logic [7:0]  wait_q;
	logic [7:0]  wait_d;
	logic [13:0] res_q;
	logic [13:0] res_d;
	logic        valid_q;
	logic        valid_d;
	logic        run_q;
	logic        run_d;
	logic        fall;

	assign fall = status_prev_q && !status_sync_q[1];

	always_comb
	begin
		state_d = state_q;
		wait_d  = wait_q;
		res_d   = res_q;
		valid_d = 1'b0;
		run_d   = 1'b0;
		unique case (state_q)
			IDLE:
			begin
				if (start_in)
				begin
					// One pulse starts one conversion; a held level would restart it when it ends.
					run_d   = 1'b1;
					state_d = WAIT_STATUS;
				end
			end
			WAIT_STATUS:
			begin
				if (fall)
				begin
					wait_d  = 8'h00;
					state_d = both_bytes_in ? READ_BOTH : READ_HIGH;
				end
			end
			READ_HIGH, READ_LOW, READ_BOTH:
			begin
				wait_d = wait_q + 8'h01;
				// Enables are held long enough to cover both pin synchronisers.
				if (wait_q == 8'(result_port_pkg::RUN_CYC))
				begin
					wait_d = 8'h00;
					if (state_q == READ_HIGH)
					begin
						res_d[13:8] = data_sync2_q[13:8];
						state_d     = READ_LOW;
					end
					else
					begin
						if (state_q == READ_BOTH)
						begin
							res_d = data_sync2_q;
						end
						else
						begin
							res_d[7:0] = data_sync2_q[7:0];
						end
						valid_d = 1'b1;
						state_d = IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			state_q       <= IDLE;
			wait_q        <= 8'h00;
			res_q         <= 14'h0000;
			valid_q       <= 1'b0;
			run_q         <= 1'b0;
			status_sync_q <= 2'b00;
			status_prev_q <= 1'b0;
			data_sync1_q  <= 14'h0000;
			data_sync2_q  <= 14'h0000;
		end
		else
		begin
			state_q       <= state_d;
			wait_q        <= wait_d;
			res_q         <= res_d;
			valid_q       <= valid_d;
			run_q         <= run_d;
			status_sync_q <= {status_sync_q[0], port.status};
			status_prev_q <= status_sync_q[1];
			data_sync1_q  <= port.data & port.data_oe;
			data_sync2_q  <= data_sync1_q;
		end
	end

	assign port.send                = 1'b1;
	assign port.run_hold            = run_q;
	assign port.chip_enable_n       = !(state_q inside {READ_HIGH, READ_LOW, READ_BOTH});
	assign port.upper_byte_select_n = !(state_q inside {READ_HIGH, READ_BOTH});
	assign port.lower_byte_select_n = !(state_q inside {READ_LOW, READ_BOTH});
	assign busy_out                 = (state_q != IDLE);
	assign result_valid_out         = valid_q;
	assign result_out               = res_q;
endmodule // result_port_host
`default_nettype wire

/* File: tb/result_port_monitor.sv */
// Checker for the wires between the converter result port and its reader.
// Assumes the testbench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module result_port_monitor (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic        chip_enable_n_in,
	input  wire logic        upper_byte_select_n_in,
	input  wire logic        lower_byte_select_n_in,
	input  wire logic        send_in,
	input  wire logic        run_hold_in,
	input  wire logic        status_in,
	input  wire logic [13:0] data_oe_in
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	wire logic lo_on = !chip_enable_n_in && !lower_byte_select_n_in;
	wire logic hi_on = !chip_enable_n_in && !upper_byte_select_n_in;
	// The enables pass two sync flops, so drive lags the pins by two edges.
	a_low_byte_drive: assert property (data_oe_in[7:0] == {8{$past(lo_on, 2)}})
		else $error("low byte drive differs from enables");
	a_high_byte_drive: assert property (data_oe_in[13:8] == {6{$past(hi_on, 2)}})
		else $error("high byte drive differs from enables");
	a_idle_high_z: assert property (chip_enable_n_in && $past(chip_enable_n_in) && $past(chip_enable_n_in, 2)
		|-> data_oe_in == 14'h0000)
		else $error("port drives without chip enable");
	a_send_held: assert property (send_in)
		else $error("send left low in direct mode");
	a_fall_then_read: assert property ($fell(status_in) |-> ##[1:8] !chip_enable_n_in)
		else $error("no read after status fell");
	a_read_after_fall: assert property ($fell(chip_enable_n_in) |-> !status_in)
		else $error("read before status fell");
	a_strobe_width: assert property ($fell(chip_enable_n_in) |=> !chip_enable_n_in [*8])
		else $error("chip enable strobe too short");
	a_run_starts: assert property ($rose(run_hold_in) |-> ##[1:4] status_in)
		else $error("run did not start a conversion");
	c_status_fall: cover property ($fell(status_in));
	c_both_bytes: cover property (lo_on && hi_on);
	c_high_only: cover property (hi_on && !lo_on);
	c_low_only: cover property (lo_on && !hi_on);
endmodule // result_port_monitor
`default_nettype wire

/* File: tb/adc_result_port_and_counter_test_tb.sv */
// Testbench joining converter port and bus reader through the interface.
// Assumes one 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_result_port_and_counter_test_tb;
	logic                          mclk;
	logic                          resetn;
	result_port_pkg::test_level_t  test_level;
	logic                          conv_done;
	logic [11:0]                   magnitude;
	logic                          sign_bit;
	logic                          overrange;
	logic                          count_clk;
	logic                          start;
	logic                          both_bytes;
	logic                          result_valid;
	logic [13:0]                   result;
	logic [13:0]                   counter;
	logic                          converting;
	logic                          host_busy;
	int                            bad_count = 0;
	int                            compares = 0;
	result_port_if bus ();
	result_port_device i_result_port_device (.mclk_in(mclk), .resetn_in(resetn), .test_level_in(test_level),
		.conv_done_in(conv_done), .magnitude_in(magnitude), .sign_bit_in(sign_bit), .overrange_in(overrange),
		.count_clk_in(count_clk), .converting_out(converting), .counter_out(counter), .port(bus.device));
	result_port_host i_result_port_host (.mclk_in(mclk), .resetn_in(resetn), .start_in(start),
		.both_bytes_in(both_bytes), .busy_out(host_busy), .result_valid_out(result_valid), .result_out(result),
		.port(bus.host));
	result_port_monitor i_result_port_monitor (.mclk_in(mclk), .resetn_in(resetn),
		.chip_enable_n_in(bus.chip_enable_n), .upper_byte_select_n_in(bus.upper_byte_select_n),
		.lower_byte_select_n_in(bus.lower_byte_select_n), .send_in(bus.send), .run_hold_in(bus.run_hold),
		.status_in(bus.status), .data_oe_in(bus.data_oe));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic give_verdict();
		$display("Counts: %0d compares, %0d bad", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// A wait that runs out of time ends the run rather than hanging it.
	task automatic must(input logic ok);
		if (ok !== 1'b1)
		begin
			bad_count++;
			give_verdict();
		end
	endtask
	task automatic pulse_count(input int n);
		repeat (n)
		begin
			count_clk = 1'b1;
			tick(1);
			count_clk = 1'b0;
			tick(1);
		end
	endtask
	task automatic read_result(input logic both, input logic [13:0] val);
		int i;
		{overrange, sign_bit, magnitude} = val;
		both_bytes = both;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		chk("host busy", {13'h0000, host_busy}, 14'h0001);
		for (i = 0; i < 20 && bus.status !== 1'b1; i++)
			tick(1);
		must(bus.status);
		chk("converting", {13'h0000, converting}, 14'h0001);
		conv_done = 1'b1;
		tick(1);
		conv_done = 1'b0;
		chk("status low", {13'h0000, bus.status}, 14'h0000);
		for (i = 0; i < 200 && result_valid !== 1'b1; i++)
			tick(1);
		must(result_valid);
		chk("result", result, val);
		tick(4);
		chk("idle drive", bus.data_oe, 14'h0000);
		chk("host idle", {13'h0000, host_busy}, 14'h0000);
	endtask
	initial
	begin
		resetn = 1'b0;
		test_level = result_port_pkg::TEST_SUPPLY;
		{conv_done, count_clk, start, both_bytes} = 4'h0;
		{overrange, sign_bit, magnitude} = 14'h0000;
		tick(8);
		resetn = 1'b1;
		tick(2);
		read_result(1'b0, 14'h1A5C);
		read_result(1'b1, 14'h2F03);
		$display("Test bus reads done");
		test_level = result_port_pkg::TEST_GROUND;
		tick(4);
		chk("ground counter", counter, result_port_pkg::CNT_ALL_ONE);
		pulse_count(3);
		chk("stopped counter", counter, result_port_pkg::CNT_ALL_ONE);
		test_level = result_port_pkg::TEST_MID;
		tick(4);
		chk("cleared counter", counter, result_port_pkg::CNT_RESET);
		chk("live view cleared", bus.data, result_port_pkg::CNT_RESET);
		pulse_count(4095);
		chk("full scale", counter, {2'h0, result_port_pkg::FULL_SCALE});
		chk("live view", bus.data, {2'h0, result_port_pkg::FULL_SCALE});
		pulse_count(1);
		chk("overrange", counter, 14'h2000);
		test_level = result_port_pkg::TEST_GROUND;
		tick(4);
		test_level = result_port_pkg::TEST_SUPPLY;
		tick(4);
		chk("supply clears", counter, result_port_pkg::CNT_RESET);
		chk("latched view", bus.data, 14'h2F03);
		$display("Test counter done");
		give_verdict();
	end
endmodule // adc_result_port_and_counter_test_tb
`default_nettype wire
